// *** inc/sri_defines.vh ***
// Register map, field positions and reset values for the status and fill block
`ifndef SRI_DEFINES_VH
`define SRI_DEFINES_VH

// Register offsets
`define SRI_ADDR_FILL_CFG 8'h08
`define SRI_ADDR_IRQ_MASK 8'h0a
`define SRI_ADDR_IRQ_CAUSE 8'h0b
`define SRI_ADDR_SNAPSHOT 8'h0c

// Reset values
`define SRI_FILL_CFG_RST 8'h00
`define SRI_IRQ_MASK_RST 8'h00
`define SRI_IRQ_CAUSE_RST 8'h00

// Fill configuration fields
`define SRI_CFG_SUBST_SEL 5
`define SRI_CFG_BYPASS_BAD 6

// Interrupt cause and mask bit positions
`define SRI_EV_LOCK 0
`define SRI_EV_INVALID 1
`define SRI_EV_CHAN_STAT 2
`define SRI_EV_CORRUPT 3
`define SRI_EV_PAYLOAD 4
`define SRI_EV_COPYRIGHT 5
`define SRI_EV_EMPHASIS 6
`define SRI_EV_RATE 7

// Snapshot field positions
`define SRI_SNAP_AUDIO_N 0
`define SRI_SNAP_BURST 1
`define SRI_SNAP_COPY_FREE 2
`define SRI_SNAP_PREEMPH 3
`define SRI_SNAP_RATE_LO 4
`define SRI_SNAP_UNLOCK 6

// Burst sync: count of zero words before the two preamble words
`define SRI_SYNC_ZERO_WORDS 3'h4

`endif

// *** hdl/sri_status_irq.v ***
// Receiver status flags, interrupt mask and cause logic, and errored-sample fill
`timescale 1ns/100ps
`include "sri_defines.vh"

module sri_status_irq #(
  parameter DATA_W = 24,
  parameter [15:0] PREAMBLE_A = 16'hf872,
  parameter [15:0] PREAMBLE_B = 16'h4e1f,
  parameter [15:0] BURST_HOLD = 16'h2000
) (
  // Clock, reset, enable
  input wire mclk_in,
  input wire nrst_in,
  input wire ce_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [7:0] reg_rdata_out,
  // Recovered channel status and lock
  input wire cs_audio_n_in,
  input wire copy_free_flag_in,
  input wire preemphasis_flag_in,
  input wire [1:0] rate_class_in,
  input wire unlock_in,
  input wire chan_stat_refresh_in,
  // Recovered sub-frame stream
  input wire sf_strobe_in,
  input wire sf_chan_b_in,
  input wire [DATA_W-1:0] sf_data_in,
  input wire sf_validity_in,
  input wire sf_biphase_err_in,
  input wire sf_parity_err_in,
  input wire sf_preamble_err_in,
  // Audio interface path
  output wire aif_strobe_out,
  output wire aif_chan_b_out,
  output wire [DATA_W-1:0] aif_data_out,
  // Transmitter path
  output wire tx_strobe_out,
  output wire tx_chan_b_out,
  output wire [DATA_W-1:0] tx_data_out,
  // Flags and interrupt
  output wire frame_corrupt_flag_out,
  output wire invalid_flag_out,
  output wire non_audio_out,
  output wire int_n_out
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg [1:0] rst_sync_r;
  wire rst_n;

  // Two stages so release is clean against the clock
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] fill_cfg_r;
  reg [7:0] irq_mask_r;
  reg [7:0] irq_cause_r;
  reg [7:0] irq_cause_nxt;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  wire [7:0] snapshot;
  wire cause_rd;

  assign cause_rd = reg_rd_in && (reg_addr_in == `SRI_ADDR_IRQ_CAUSE);

  // Writable registers; mask resets to all enabled
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      fill_cfg_r <= `SRI_FILL_CFG_RST;
      irq_mask_r <= `SRI_IRQ_MASK_RST;
    end else if (ce_in && reg_wr_in) begin
      if (reg_addr_in == `SRI_ADDR_FILL_CFG) begin
        fill_cfg_r <= reg_wdata_in;
      end else if (reg_addr_in == `SRI_ADDR_IRQ_MASK) begin
        irq_mask_r <= reg_wdata_in;
      end
    end
  end

  // Read decode; unmapped offsets return zero
  always @* begin
    if (reg_addr_in == `SRI_ADDR_FILL_CFG) begin
      rdata_nxt = fill_cfg_r;
    end else if (reg_addr_in == `SRI_ADDR_IRQ_MASK) begin
      rdata_nxt = irq_mask_r;
    end else if (reg_addr_in == `SRI_ADDR_IRQ_CAUSE) begin
      rdata_nxt = irq_cause_r;
    end else if (reg_addr_in == `SRI_ADDR_SNAPSHOT) begin
      rdata_nxt = snapshot;
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  // Read data held until the next read
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata_out = rdata_r;

  // ----------------------------------------
  // Burst sync detection
  // ----------------------------------------
  reg [2:0] zero_cnt_r;
  reg pa_seen_r;
  reg burst_r;
  reg [15:0] hold_cnt_r;
  wire [15:0] word;
  wire sync_hit;

  // The upper 16 bits of each sub-frame carry the payload word
  assign word = sf_data_in[DATA_W-1:DATA_W-16];
  assign sync_hit = sf_strobe_in && pa_seen_r && (word == PREAMBLE_B);

  // Zero run, then Pa, then Pb; any other word restarts the hunt
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      zero_cnt_r <= 3'h0;
      pa_seen_r <= 1'b0;
    end else if (ce_in && sf_strobe_in) begin
      if (word == 16'h0000) begin
        pa_seen_r <= 1'b0;
        if (zero_cnt_r != `SRI_SYNC_ZERO_WORDS) begin
          zero_cnt_r <= zero_cnt_r + 3'h1;
        end
      end else if (zero_cnt_r == `SRI_SYNC_ZERO_WORDS && word == PREAMBLE_A) begin
        pa_seen_r <= 1'b1;
        zero_cnt_r <= 3'h0;
      end else begin
        pa_seen_r <= 1'b0;
        zero_cnt_r <= 3'h0;
      end
    end
  end

  // Flag holds for BURST_HOLD sub-frames after the last sync, so gaps
  // between bursts do not make it flicker back to audio
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      burst_r <= 1'b0;
      hold_cnt_r <= 16'h0000;
    end else if (ce_in) begin
      if (sync_hit) begin
        burst_r <= 1'b1;
        hold_cnt_r <= BURST_HOLD;
      end else if (sf_strobe_in && burst_r) begin
        if (hold_cnt_r == 16'h0000) begin
          burst_r <= 1'b0;
        end else begin
          hold_cnt_r <= hold_cnt_r - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Status snapshot and error flags
  // ----------------------------------------
  reg corrupt_r;
  reg invalid_r;

  assign snapshot = {1'b0,
                     unlock_in,
                     rate_class_in,
                     preemphasis_flag_in,
                     copy_free_flag_in,
                     burst_r,
                     cs_audio_n_in};
  assign non_audio_out = cs_audio_n_in | burst_r;

  // Flags follow the most recent sub-frame
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      corrupt_r <= 1'b0;
      invalid_r <= 1'b0;
    end else if (ce_in && sf_strobe_in) begin
      corrupt_r <= sf_biphase_err_in | sf_parity_err_in | sf_preamble_err_in;
      invalid_r <= sf_validity_in;
    end
  end
  assign frame_corrupt_flag_out = corrupt_r;
  assign invalid_flag_out = invalid_r;

  // ----------------------------------------
  // Interrupt causes
  // ----------------------------------------
  reg [6:0] prev_r;
  reg chan_prev_r;
  reg [7:0] src;
  wire [6:0] cur;

  // Previous values for edge and change detection
  assign cur = {rate_class_in, preemphasis_flag_in, copy_free_flag_in,
                burst_r, cs_audio_n_in, unlock_in};
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 7'h00;
    end else if (ce_in) begin
      prev_r <= cur;
    end
  end

  // Source events; rate counts as a new rise only when its class moves
  always @* begin
    src = 8'h00;
    src[`SRI_EV_LOCK] = cur[0] ^ prev_r[0];
    src[`SRI_EV_INVALID] = invalid_r;
    src[`SRI_EV_CHAN_STAT] = chan_stat_refresh_in & ~chan_prev_r;
    src[`SRI_EV_CORRUPT] = corrupt_r;
    src[`SRI_EV_PAYLOAD] = |(cur[2:1] ^ prev_r[2:1]);
    src[`SRI_EV_COPYRIGHT] = cur[3] ^ prev_r[3];
    src[`SRI_EV_EMPHASIS] = cur[4] ^ prev_r[4];
    src[`SRI_EV_RATE] = |(cur[6:5] ^ prev_r[6:5]);
  end

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      chan_prev_r <= 1'b0;
    end else if (ce_in) begin
      chan_prev_r <= chan_stat_refresh_in;
    end
  end

  // Read clears, but a source firing in the same cycle still lands
  always @* begin
    irq_cause_nxt = cause_rd ? 8'h00 : irq_cause_r;
    irq_cause_nxt = irq_cause_nxt | (src & ~irq_mask_r);
  end

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_cause_r <= `SRI_IRQ_CAUSE_RST;
    end else if (ce_in) begin
      irq_cause_r <= irq_cause_nxt;
    end
  end

  // Mask applied again so masking a pending cause drops the line at once
  assign int_n_out = ~|(irq_cause_r & ~irq_mask_r);

  // ----------------------------------------
  // Error fill
  // ----------------------------------------
  reg [DATA_W-1:0] last_good_r;
  reg [DATA_W-1:0] aif_data_r;
  reg [DATA_W-1:0] tx_data_r;
  reg aif_strobe_r;
  reg aif_chan_r;
  reg tx_chan_r;
  wire sf_corrupt;
  wire inv_sub;
  wire aif_sub;
  wire [DATA_W-1:0] fill_word;

  assign sf_corrupt = sf_biphase_err_in | sf_parity_err_in | sf_preamble_err_in;
  // Unmasked flags never substitute; host is told through the interrupt
  assign inv_sub = sf_validity_in & irq_mask_r[`SRI_EV_INVALID] &
                   ~fill_cfg_r[`SRI_CFG_BYPASS_BAD];
  assign aif_sub = inv_sub | (sf_corrupt & irq_mask_r[`SRI_EV_CORRUPT]);
  assign fill_word = fill_cfg_r[`SRI_CFG_SUBST_SEL] ?
                     {DATA_W{1'b0}} : last_good_r;

  // One store serves both paths; bad samples never reach it
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      last_good_r <= {DATA_W{1'b0}};
    end else if (ce_in && sf_strobe_in && !sf_corrupt && !sf_validity_in) begin
      last_good_r <= sf_data_in;
    end
  end

  // Output samples, one cycle after the incoming strobe
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      aif_data_r <= {DATA_W{1'b0}};
      tx_data_r <= {DATA_W{1'b0}};
      aif_strobe_r <= 1'b0;
      aif_chan_r <= 1'b0;
      tx_chan_r <= 1'b0;
    end else if (ce_in) begin
      aif_strobe_r <= sf_strobe_in;
      if (sf_strobe_in) begin
        aif_chan_r <= sf_chan_b_in;
        tx_chan_r <= sf_chan_b_in;
        aif_data_r <= aif_sub ? fill_word : sf_data_in;
        tx_data_r <= inv_sub ? fill_word : sf_data_in;
      end
    end
  end

  assign aif_strobe_out = aif_strobe_r & ce_in;
  assign aif_chan_b_out = aif_chan_r;
  assign aif_data_out = aif_data_r;
  assign tx_strobe_out = aif_strobe_r & ce_in;
  assign tx_chan_b_out = tx_chan_r;
  assign tx_data_out = tx_data_r;

endmodule

// *** verification/sri_status_irq_props.sv ***
// Port-level checks on the status, interrupt and fill block
`timescale 1ns/100ps
`include "sri_defines.vh"
module sri_status_irq_props #(parameter DATA_W = 24) (
  input wire mclk_in, nrst_in, ce_in, reg_wr_in, unlock_in, cs_audio_n_in,
  input wire [7:0] reg_addr_in, reg_wdata_in,
  input wire sf_strobe_in, sf_validity_in, sf_biphase_err_in, sf_parity_err_in,
  input wire sf_preamble_err_in, aif_strobe_out, tx_strobe_out, frame_corrupt_flag_out,
  input wire invalid_flag_out, non_audio_out, int_n_out,
  input wire [DATA_W-1:0] sf_data_in, aif_data_out, tx_data_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  reg [7:0] msk_r;
  reg [7:0] cfg_r;
  wire err_w = sf_biphase_err_in | sf_parity_err_in | sf_preamble_err_in;
  // Mirror of mask and fill config, so checks know what the host set
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      msk_r <= `SRI_IRQ_MASK_RST;
      cfg_r <= `SRI_FILL_CFG_RST;
    end else if (ce_in && reg_wr_in) begin
      if (reg_addr_in == `SRI_ADDR_IRQ_MASK)
        msk_r <= reg_wdata_in;
      if (reg_addr_in == `SRI_ADDR_FILL_CFG)
        cfg_r <= reg_wdata_in;
    end
  end
  sequence take_s;
    sf_strobe_in && ce_in;
  endsequence
  a_strobe_pass: assert property (take_s |=> aif_strobe_out && tx_strobe_out)
    else $error("output strobes missing");
  a_flag_track: assert property (take_s |=> frame_corrupt_flag_out == $past(err_w)
    && invalid_flag_out == $past(sf_validity_in)) else $error("error flags wrong");
  a_clean_pass: assert property (take_s ##0 !msk_r[1] && !msk_r[3]
    |=> aif_data_out == $past(sf_data_in)) else $error("unmasked data changed");
  a_tx_corrupt: assert property (take_s ##0 !sf_validity_in
    |=> tx_data_out == $past(sf_data_in)) else $error("tx data substituted");
  a_zero_fill: assert property (take_s ##0 err_w && msk_r[3] && cfg_r[5]
    |=> aif_data_out == 0) else $error("zero fill missing");
  a_bypass_bad: assert property (take_s ##0 !err_w && cfg_r[6]
    |=> aif_data_out == $past(sf_data_in)) else $error("bypass data changed");
  a_audio_or: assert property (cs_audio_n_in |-> non_audio_out)
    else $error("non audio not set");
  a_lock_irq: assert property ($changed(unlock_in) && !msk_r[0]
    |-> ##[1:2] !int_n_out) else $error("lock change no interrupt");
  a_mask_quiet: assert property (msk_r == 8'hff |-> int_n_out)
    else $error("masked interrupt seen");
endmodule
bind sri_status_irq sri_status_irq_props #(.DATA_W(DATA_W)) chk_u (.mclk_in, .nrst_in,
  .ce_in, .reg_wr_in, .unlock_in, .cs_audio_n_in, .reg_addr_in, .reg_wdata_in,
  .sf_strobe_in, .sf_validity_in, .sf_biphase_err_in, .sf_parity_err_in,
  .sf_preamble_err_in, .aif_strobe_out, .tx_strobe_out, .frame_corrupt_flag_out,
  .invalid_flag_out, .non_audio_out, .int_n_out, .sf_data_in, .aif_data_out,
  .tx_data_out);

// *** verification/sri_src_model.sv ***
// Sub-frame source standing in for the recovered stream
`timescale 1ns/100ps
module sri_src_model (
  input wire mclk_in,
  output reg sf_strobe_out = 0,
  output reg sf_chan_b_out = 0,
  output reg [23:0] sf_data_out = 0,
  output reg sf_validity_out = 0,
  output reg [2:0] sf_err_out = 0
);
  // One sub-frame; data shows no stale value once the strobe is gone
  task send(input [23:0] d, input v, input [2:0] e);
    begin
      @(posedge mclk_in);
      #1;
      sf_strobe_out = 1;
      sf_data_out = d;
      sf_validity_out = v;
      sf_err_out = e;
      @(posedge mclk_in);
      #1;
      sf_strobe_out = 0;
      sf_data_out = ~d;
      sf_chan_b_out = ~sf_chan_b_out;
    end
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the status, interrupt and fill block
`timescale 1ns/100ps
module tb;
  localparam [15:0] PA = 16'h1234; // Arbitrary sync word
  localparam [15:0] PB = 16'h5678; // Arbitrary sync word
  reg mclk_in = 0, nrst_in = 0, ce_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  reg [7:0] reg_addr_in = 0, reg_wdata_in = 0, r, msk = 0, cfg = 0;
  reg cs_audio_n_in = 0, copy_free_flag_in = 0, preemphasis_flag_in = 0;
  reg unlock_in = 0, chan_stat_refresh_in = 0;
  reg [1:0] rate_class_in = 0;
  reg [23:0] last = 0;
  integer i, t = 0, cyc = 0, err_count = 0, check_count = 0;
  wire sf_strobe_in, sf_chan_b_in, sf_validity_in, aif_strobe_out, aif_chan_b_out;
  wire tx_strobe_out, tx_chan_b_out, frame_corrupt_flag_out, invalid_flag_out;
  wire non_audio_out, int_n_out;
  wire [2:0] err;
  wire [7:0] reg_rdata_out;
  wire [23:0] sf_data_in, aif_data_out, tx_data_out;
  always #4 mclk_in = ~mclk_in;
  sri_src_model src_u (.mclk_in, .sf_strobe_out(sf_strobe_in), .sf_chan_b_out(sf_chan_b_in),
    .sf_data_out(sf_data_in), .sf_validity_out(sf_validity_in), .sf_err_out(err));
  sri_status_irq #(.PREAMBLE_A(PA), .PREAMBLE_B(PB), .BURST_HOLD(16'h0004)) dut_u (
    .mclk_in, .nrst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .cs_audio_n_in, .copy_free_flag_in, .preemphasis_flag_in,
    .rate_class_in, .unlock_in, .chan_stat_refresh_in, .sf_strobe_in, .sf_chan_b_in,
    .sf_data_in, .sf_validity_in, .sf_biphase_err_in(err[0]), .sf_parity_err_in(err[1]),
    .sf_preamble_err_in(err[2]), .aif_strobe_out, .aif_chan_b_out, .aif_data_out,
    .tx_strobe_out, .tx_chan_b_out, .tx_data_out, .frame_corrupt_flag_out,
    .invalid_flag_out, .non_audio_out, .int_n_out);
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [23:0] g, input [23:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("Error at %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task done;
    begin
      $display("test %0d done", t);
      t = t + 1;
    end
  endtask
  // Register port: one-cycle strobes, read data the cycle after
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk_in);
      #1;
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1;
      @(posedge mclk_in);
      #1;
      reg_wr_in = 0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge mclk_in);
      #1;
      reg_addr_in = a;
      reg_rd_in = 1;
      @(posedge mclk_in);
      #1;
      reg_rd_in = 0;
      @(posedge mclk_in);
      #1;
      d = reg_rdata_out;
    end
  endtask
  task idle(input integer n);
    begin
      repeat (n) @(posedge mclk_in);
      #1;
    end
  endtask
  // Expected sample on a path: zeros or last clean sample when substituted
  function [23:0] exp_word(input [23:0] d, input s);
    begin
      exp_word = s ? (cfg[5] ? 24'h00_0000 : last) : d;
    end
  endfunction
  // One sub-frame with expectations worked out from mask and fill config
  task sf(input [23:0] d, input v, input [2:0] e);
    reg inv;
    reg bad;
    reg cb;
    begin
      inv = v && msk[1] && !cfg[6];
      bad = (e != 0) && msk[3];
      cb = sf_chan_b_in;
      src_u.send(d, v, e);
      chk(aif_data_out, exp_word(d, inv || bad));
      chk(tx_data_out, exp_word(d, inv));
      chk(aif_chan_b_out, cb);
      chk(tx_chan_b_out, cb);
      chk(frame_corrupt_flag_out, e != 0);
      chk(invalid_flag_out, v);
      if (!v && e == 0)
        last = d;
    end
  endtask
  // Hang guard
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  initial begin
    i = $urandom(55);
    idle(8);
    nrst_in = 1;
    idle(3);
    rd(8'h0a, r); chk(r, 8'h00);
    wr(8'h33, 8'hff);
    rd(8'h33, r); chk(r, 8'h00);
    rd(8'h0a, r); chk(r, 8'h00);
    done;
    for (i = 0; i < 4; i = i + 1) begin
      {cs_audio_n_in, copy_free_flag_in, preemphasis_flag_in, unlock_in} = 4'($urandom);
      rate_class_in = i[1:0];
      rd(8'h0c, r);
      chk(r, {1'b0, unlock_in, rate_class_in, preemphasis_flag_in, copy_free_flag_in,
        1'b0, cs_audio_n_in});
      chk(non_audio_out, cs_audio_n_in);
    end
    done;
    msk = 8'hff;
    wr(8'h0a, msk);
    rd(8'h0b, r);
    unlock_in = ~unlock_in;
    rate_class_in = rate_class_in + 2'h1;
    chan_stat_refresh_in = 1;
    idle(3);
    chk(int_n_out, 1);
    rd(8'h0b, r); chk(r, 8'h00);
    chan_stat_refresh_in = 0;
    msk = 8'hfe;
    wr(8'h0a, msk);
    unlock_in = ~unlock_in;
    idle(2);
    chk(int_n_out, 0);
    rd(8'h0b, r); chk(r, 8'h01);
    rd(8'h0b, r); chk(r, 8'h00);
    chk(int_n_out, 1);
    msk = 8'hfb;
    wr(8'h0a, msk);
    chan_stat_refresh_in = 1;
    idle(2);
    rd(8'h0b, r); chk(r, 8'h04);
    rd(8'h0b, r); chk(r, 8'h00);
    done;
    msk = 8'hf7;
    wr(8'h0a, msk);
    sf(24'($urandom), 0, 3'b100);
    rd(8'h0b, r); chk(r, 8'h08);
    rd(8'h0b, r); chk(r, 8'h08);
    sf(24'($urandom), 0, 3'b000);
    rd(8'h0b, r);
    rd(8'h0b, r); chk(r, 8'h00);
    done;
    msk = 8'hef;
    wr(8'h0a, msk);
    rd(8'h0b, r);
    for (i = 0; i < 6; i = i + 1)
      sf({(i < 4) ? 16'h0000 : ((i == 4) ? PA : PB), 8'h00}, 0, 3'b000);
    rd(8'h0c, r); chk(r[1], 1);
    chk(non_audio_out, 1);
    rd(8'h0b, r); chk(r, 8'h10);
    // Enable low must freeze the mask against a write
    ce_in = 0;
    wr(8'h0a, 8'h00);
    ce_in = 1;
    rd(8'h0a, r); chk(r, msk);
    done;
    for (i = 0; i < 40; i = i + 1) begin
      if (i % 8 == 0) begin
        cfg = {1'b0, 2'($urandom), 5'h00};
        msk = 8'($urandom);
        wr(8'h08, cfg);
        wr(8'h0a, msk);
        rd(8'h08, r); chk(r, cfg);
      end
      sf(24'($urandom), 1'($urandom), 3'($urandom));
    end
    done;
    tally_and_finish;
  end
endmodule
